// ==== gate_exec_pkg.sv ====
// Overview of operation
// - the block and release ops gate process and time interrupts alike.
// - after the block op no further interrupt is serviced until release.
// - the release op undoes the block op and servicing resumes.
// - both gating ops run regardless of the logic result bit and keep it and the codes.
// - requests arriving while gated stay pending and are serviced after release.
// - the indexed prefix is a two-word instruction run regardless of the logic result bit.
// - the prefix word names a marker or data word; the next word gives op and operand class.
// - the following instruction runs with the parameter taken from the named index word.
// - for bit operands the bit number is the high byte and the byte number the low byte.
// - only the permitted operation groups may follow the prefix.
// - with a marker index, an and-scan of an input above byte 127 becomes one of an output.
// - the index word number is 0 to 254 for marker words and 0 to 255 for data words.
package gate_exec_pkg;

    // ========================================
    // instruction word layout and op codes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_INT_BLOCK = 8'h01;
    localparam logic [7:0] OP_INT_RELEASE = 8'h02;
    localparam logic [7:0] OP_DO_MARKER = 8'h03;
    localparam logic [7:0] OP_DO_DATA = 8'h04;
    // bit operand ops live in 8'h40..8'h5f, word ops in 8'h60..8'h7f
    localparam logic [7:0] OP_AND_INPUT = 8'h40;
    localparam logic [7:0] OP_AND_OUTPUT = 8'h41;
    localparam logic [2:0] BIT_GROUP = 3'h2;
    localparam logic [2:0] WORD_GROUP = 3'h3;

    // ========================================
    // index limits
    localparam logic [7:0] MARKER_IDX_MAX = 8'hfe;
    localparam logic [7:0] DATA_IDX_MAX = 8'hff;
    localparam logic [7:0] INPUT_BYTE_MAX = 8'h7f;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ========================================
    // carriers
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] param;
    } ins_word_t;

    typedef struct packed {
        logic [7:0] op;
        logic [15:0] param;
    } exec_t;

    localparam exec_t EXEC_RESET = '{op: 8'h00, param: 16'h0000};

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_INDEX = 2'b01,
        S_FOLLOW = 2'b10
    } seq_state_t;

    // ========================================
    // op classification
    function automatic logic isBitOp(input logic [7:0] op);
        isBitOp = (op[7:5] == BIT_GROUP);
    endfunction : isBitOp

    function automatic logic isIndexable(input logic [7:0] op);
        isIndexable = (op[7:5] == BIT_GROUP) || (op[7:5] == WORD_GROUP);
    endfunction : isIndexable

endpackage : gate_exec_pkg

// ==== irq_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
module irq_gate (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // gate control
    input wire logic blockPulse,
    input wire logic releasePulse,
    input wire logic busy,
    // requests and acknowledges
    input wire logic procReq,
    input wire logic timeReq,
    input wire logic procAck,
    input wire logic timeAck,
    // state
    output logic gateClosed,
    output logic procPending,
    output logic timePending,
    output logic procService,
    output logic timeService
);

    // ========================================
    // gate and pending flags, set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gateClosed <= 1'b0;
            procPending <= 1'b0;
            timePending <= 1'b0;
        end else begin
            if (blockPulse) begin
                gateClosed <= 1'b1;
            end else if (releasePulse) begin
                gateClosed <= 1'b0;
            end
            procPending <= procReq | (procPending & ~procAck);
            timePending <= timeReq | (timePending & ~timeAck);
        end
    end

    // ========================================
    // service offered only with gate open and no two-word op in flight
    wire open = ~gateClosed & ~blockPulse & ~busy;
    assign procService = procPending & open;
    assign timeService = timePending & open;

endmodule : irq_gate
`default_nettype wire

// ==== index_resolve.sv ====
`timescale 1ns/10ps
`default_nettype none
module index_resolve (
    // prefix context
    input wire logic isMarker,
    input wire logic [15:0] indexWord,
    // following instruction
    input wire gate_exec_pkg::ins_word_t follow,
    // result
    output gate_exec_pkg::exec_t resolved,
    output logic permitted
);

    // ========================================
    // op substitution and parameter replacement
    wire bitOp = gate_exec_pkg::isBitOp(follow.op);
    wire [7:0] byteNum = indexWord[7:0];
    wire [7:0] bitNum = indexWord[15:8];
    wire toOutput = isMarker && (follow.op == gate_exec_pkg::OP_AND_INPUT)
        && (byteNum > gate_exec_pkg::INPUT_BYTE_MAX);

    assign permitted = gate_exec_pkg::isIndexable(follow.op);
    assign resolved.op = toOutput ? gate_exec_pkg::OP_AND_OUTPUT : follow.op;
    assign resolved.param = bitOp ? {bitNum, byteNum} : indexWord;

endmodule : index_resolve
`default_nettype wire

// ==== gate_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
module gate_exec (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction stream from decode
    input wire logic insValid,
    output logic insReady,
    input wire gate_exec_pkg::ins_word_t insWord,
    // index word read port
    output logic idxRdReq,
    output logic idxRdData,
    output logic [7:0] idxRdAddr,
    input wire logic idxRdValid,
    input wire logic [15:0] idxRdWord,
    // execution output
    output logic execValid,
    output gate_exec_pkg::exec_t execIns,
    // status pulses
    output logic flagsKeep,
    output logic illegalFollow,
    output logic rangeError,
    // interrupt requests and service
    input wire logic procReq,
    input wire logic timeReq,
    input wire logic procAck,
    input wire logic timeAck,
    output logic procService,
    output logic timeService,
    output logic procPending,
    output logic timePending,
    output logic gateClosed
);

    // ========================================
    // sequencer state
    gate_exec_pkg::seq_state_t state;
    gate_exec_pkg::seq_state_t next_state;

    // prefix context
    logic prefixMarker;
    logic [15:0] indexWord;

    // ========================================
    // decode of the word offered in idle
    wire take = insValid & insReady;
    wire inIdle = (state == gate_exec_pkg::S_IDLE);
    wire inIndex = (state == gate_exec_pkg::S_INDEX);
    wire inFollow = (state == gate_exec_pkg::S_FOLLOW);

    wire opBlock = (insWord.op == gate_exec_pkg::OP_INT_BLOCK);
    wire opRelease = (insWord.op == gate_exec_pkg::OP_INT_RELEASE);
    wire opDoMarker = (insWord.op == gate_exec_pkg::OP_DO_MARKER);
    wire opDoData = (insWord.op == gate_exec_pkg::OP_DO_DATA);
    wire opPrefix = opDoMarker | opDoData;

    // gating ops take effect on the word taken, no logic result check
    wire blockPulse = take & inIdle & opBlock;
    wire releasePulse = take & inIdle & opRelease;

    // marker words pair two bytes, so the last number is not usable
    wire markerRangeBad = opDoMarker
        && (insWord.param > gate_exec_pkg::MARKER_IDX_MAX);
    wire dataRangeBad = opDoData
        && (insWord.param > gate_exec_pkg::DATA_IDX_MAX);
    wire prefixBad = markerRangeBad | dataRangeBad;

    wire prefixStart = take & inIdle & opPrefix & ~prefixBad;
    wire prefixRefused = take & inIdle & opPrefix & prefixBad;
    wire plainIns = take & inIdle & ~opBlock & ~opRelease & ~opPrefix;

    // ========================================
    // resolution of the following word
    gate_exec_pkg::exec_t resolved;
    logic permitted;

    index_resolve u_resolve (
        .isMarker(prefixMarker),
        .indexWord(indexWord),
        .follow(insWord),
        .resolved(resolved),
        .permitted(permitted)
    );

    wire followTake = take & inFollow;
    wire followOk = followTake & permitted;
    wire followBad = followTake & ~permitted;

    // ========================================
    // interrupt gate, held closed over a two-word op
    irq_gate u_gate (
        .clk(clk),
        .resetn(resetn),
        .blockPulse(blockPulse),
        .releasePulse(releasePulse),
        .busy(~inIdle),
        .procReq(procReq),
        .timeReq(timeReq),
        .procAck(procAck),
        .timeAck(timeAck),
        .gateClosed(gateClosed),
        .procPending(procPending),
        .timePending(timePending),
        .procService(procService),
        .timeService(timeService)
    );

    // ========================================
    // stream handshake: stalled while the index word is read
    assign insReady = ~inIndex;

    // ========================================
    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            gate_exec_pkg::S_IDLE: begin
                if (prefixStart) begin
                    next_state = gate_exec_pkg::S_INDEX;
                end
            end
            gate_exec_pkg::S_INDEX: begin
                if (idxRdValid) begin
                    next_state = gate_exec_pkg::S_FOLLOW;
                end
            end
            gate_exec_pkg::S_FOLLOW: begin
                if (followTake) begin
                    next_state = gate_exec_pkg::S_IDLE;
                end
            end
            default: begin
                next_state = gate_exec_pkg::S_IDLE;
            end
        endcase
    end

    // ========================================
    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= gate_exec_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ========================================
    // prefix context: which word kind, and the word once read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prefixMarker <= 1'b0;
            indexWord <= 16'h0000;
        end else begin
            if (prefixStart) begin
                prefixMarker <= opDoMarker;
            end
            if (inIndex && idxRdValid) begin
                indexWord <= idxRdWord;
            end
        end
    end

    // ========================================
    // index word read request, one cycle pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idxRdReq <= 1'b0;
            idxRdData <= 1'b0;
            idxRdAddr <= 8'h00;
        end else begin
            idxRdReq <= prefixStart;
            if (prefixStart) begin
                idxRdData <= opDoData;
                idxRdAddr <= insWord.param;
            end
        end
    end

    // ========================================
    // execution output: plain words pass, indexed words resolved
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            execValid <= 1'b0;
            execIns <= gate_exec_pkg::EXEC_RESET;
        end else begin
            execValid <= plainIns | followOk;
            if (followOk) begin
                execIns <= resolved;
            end else if (plainIns) begin
                execIns <= '{op: insWord.op, param: {gate_exec_pkg::ZERO_BYTE, insWord.param}};
            end
        end
    end

    // ========================================
    // status pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flagsKeep <= 1'b0;
            illegalFollow <= 1'b0;
            rangeError <= 1'b0;
        end else begin
            // gating ops and the prefix word leave result bit and codes alone
            flagsKeep <= blockPulse | releasePulse | prefixStart;
            illegalFollow <= followBad;
            rangeError <= prefixRefused;
        end
    end

endmodule : gate_exec
`default_nettype wire

// ==== gate_exec_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================
// gating and prefix checker
module gate_exec_sva (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction stream
    input wire logic insValid,
    input wire logic insReady,
    input wire gate_exec_pkg::ins_word_t insWord,
    // index read and status
    input wire logic idxRdReq,
    input wire logic idxRdData,
    input wire logic [7:0] idxRdAddr,
    input wire logic flagsKeep,
    input wire logic rangeError,
    // interrupts
    input wire logic procReq,
    input wire logic procService,
    input wire logic timeService,
    input wire logic procPending,
    input wire logic gateClosed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // one word of the given op taken
    sequence takeOp(o);
        insValid && insReady && insWord.op == o;
    endsequence
    gate_closed_a: assert property (takeOp(gate_exec_pkg::OP_INT_BLOCK) |=> gateClosed)
        else $error("gate stays open after block op");
    gate_open_a: assert property (takeOp(gate_exec_pkg::OP_INT_RELEASE) |=> !gateClosed)
        else $error("gate stays closed after release op");
    no_service_a: assert property (gateClosed |-> !procService && !timeService)
        else $error("interrupt offered while gated");
    keep_flags_a: assert property ((takeOp(gate_exec_pkg::OP_INT_BLOCK)
        or takeOp(gate_exec_pkg::OP_INT_RELEASE)) |=> flagsKeep)
        else $error("flags not kept by gating op");
    pending_hold_a: assert property (procReq |=> procPending)
        else $error("request not held pending");
    prefix_read_a: assert property (takeOp(gate_exec_pkg::OP_DO_DATA)
        |=> idxRdReq && idxRdData && idxRdAddr == $past(insWord.param))
        else $error("index read wrong after data prefix");
    range_refuse_a: assert property (takeOp(gate_exec_pkg::OP_DO_MARKER)
        ##0 insWord.param == 8'hff |=> rangeError && !idxRdReq)
        else $error("marker number 255 not refused");
    ready_low_a: assert property (idxRdReq |-> !insReady)
        else $error("word taken during index read");
endmodule : gate_exec_sva
`default_nettype wire

// ==== idx_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================
// index word memory model
module idx_mem (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // index word read port
    input wire logic idxRdReq,
    input wire logic idxRdData,
    input wire logic [7:0] idxRdAddr,
    output logic idxRdValid,
    output logic [15:0] idxRdWord
);
    logic slow;
    logic [1:0] delayCnt;
    // marker words hold a bit number high, data words a zero high byte
    function automatic logic [15:0] wordOf(input logic d, input logic [7:0] a);
        wordOf = d ? {8'h00, a ^ 8'h3c} : {a & 8'h07, a ^ 8'h80};
    endfunction : wordOf
    // prompt and slow answers alternate; idle word toggles every cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slow <= 1'b0;
            delayCnt <= 2'h0;
            idxRdValid <= 1'b0;
            idxRdWord <= 16'h0000;
        end else begin
            idxRdValid <= 1'b0;
            idxRdWord <= ~idxRdWord;
            if (idxRdReq) begin
                slow <= ~slow;
                delayCnt <= slow ? 2'h2 : 2'h0;
            end
            if ((idxRdReq && !slow) || delayCnt == 2'h1) begin
                idxRdValid <= 1'b1;
                idxRdWord <= wordOf(idxRdData, idxRdAddr);
            end
            if (delayCnt != 2'h0) delayCnt <= delayCnt - 2'h1;
        end
    end
endmodule : idx_mem
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    // =====================================
    // wiring
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic insValid = 1'b0;
    gate_exec_pkg::ins_word_t insWord = '0;
    logic procReq = 1'b0, timeReq = 1'b0, procAck = 1'b0, timeAck = 1'b0;
    logic insReady, idxRdReq, idxRdData, idxRdValid, execValid, flagsKeep, illegalFollow;
    logic rangeError, procService, timeService, procPending, timePending, gateClosed;
    logic [7:0] idxRdAddr;
    logic [15:0] idxRdWord;
    logic [31:0] seed = 32'h94648cb0;
    logic [31:0] r;
    logic [7:0] op;
    gate_exec_pkg::exec_t execIns;
    gate_exec_pkg::exec_t notes[$];
    int n_fail = 0;
    int checks_done = 0;
    // clock
    always #12.5 clk = ~clk;
    gate_exec DUT (.clk(clk), .resetn(resetn), .insValid(insValid), .insReady(insReady),
        .insWord(insWord), .idxRdReq(idxRdReq), .idxRdData(idxRdData), .idxRdAddr(idxRdAddr),
        .idxRdValid(idxRdValid), .idxRdWord(idxRdWord), .execValid(execValid),
        .execIns(execIns), .flagsKeep(flagsKeep), .illegalFollow(illegalFollow),
        .rangeError(rangeError), .procReq(procReq), .timeReq(timeReq), .procAck(procAck),
        .timeAck(timeAck), .procService(procService), .timeService(timeService),
        .procPending(procPending), .timePending(timePending), .gateClosed(gateClosed));
    idx_mem mem (.clk(clk), .resetn(resetn), .idxRdReq(idxRdReq), .idxRdData(idxRdData),
        .idxRdAddr(idxRdAddr), .idxRdValid(idxRdValid), .idxRdWord(idxRdWord));
    // =====================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkBit(input logic got, input logic exp);
        chk({23'h0, got}, {23'h0, exp});
    endtask : chkBit
    // offer one word, valid held between back-to-back words
    task automatic send(input logic [7:0] o, input logic [7:0] p);
        int n;
        @(negedge clk);
        insValid = 1'b1;
        insWord = '{op: o, param: p};
        n = 0;
        while (insReady !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        // a stall that never ends counts as a mismatch
        if (n == 20) begin
            n_fail++;
        end
        @(posedge clk);
    endtask : send
    task automatic idle();
        @(negedge clk);
        insValid = 1'b0;
    endtask : idle
    // prefix plus follower, expected result noted first
    task automatic prefix(input logic d, input logic [7:0] a, input logic [7:0] f);
        logic [15:0] w;
        w = d ? {8'h00, a ^ 8'h3c} : {a & 8'h07, a ^ 8'h80};
        notes.push_back('{op: (!d && f == gate_exec_pkg::OP_AND_INPUT
            && w[7:0] > 8'h7f) ? gate_exec_pkg::OP_AND_OUTPUT : f, param: w});
        send(d ? gate_exec_pkg::OP_DO_DATA : gate_exec_pkg::OP_DO_MARKER, a);
        send(f, 8'h00);
    endtask : prefix
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // =====================================
    // result watcher
    always @(negedge clk) begin
        if (resetn && execValid === 1'b1) begin
            chk(execIns, (notes.size() > 0) ? notes.pop_front() : 'x);
        end
    end
    // watchdog
    initial begin
        #(25 * 4000);
        n_fail++;
        conclude();
    end
    // =====================================
    // scenarios
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            op = {2'b01, r[13], r[4:0]};
            notes.push_back('{op: op, param: {8'h00, r[23:16]}});
            send(op, r[23:16]);
        end
        prefix(1'b1, 8'hff, 8'h60);
        prefix(1'b1, r[7:0], 8'h6a);
        prefix(1'b0, 8'h05, gate_exec_pkg::OP_AND_INPUT);
        prefix(1'b0, 8'h93, gate_exec_pkg::OP_AND_INPUT);
        prefix(1'b0, 8'hfe, 8'h45);
        send(gate_exec_pkg::OP_DO_MARKER, 8'hff);
        idle();
        chkBit(rangeError, 1'b1);
        send(gate_exec_pkg::OP_DO_DATA, 8'h10);
        send(8'h10, 8'h00);
        idle();
        chkBit(illegalFollow, 1'b1);
        send(gate_exec_pkg::OP_INT_BLOCK, r[15:8]);
        idle();
        chkBit(gateClosed, 1'b1);
        chkBit(flagsKeep, 1'b1);
        procReq = 1'b1;
        timeReq = 1'b1;
        @(negedge clk);
        procReq = 1'b0;
        timeReq = 1'b0;
        chkBit(timeService, 1'b0);
        chkBit(timePending, 1'b1);
        notes.push_back('{op: 8'h60, param: 16'h0011});
        send(8'h60, 8'h11);
        send(gate_exec_pkg::OP_INT_RELEASE, 8'h00);
        idle();
        chkBit(gateClosed, 1'b0);
        chkBit(procService, 1'b1);
        chkBit(timeService, 1'b1);
        procAck = 1'b1;
        timeAck = 1'b1;
        @(negedge clk);
        procAck = 1'b0;
        timeAck = 1'b0;
        repeat (4) @(negedge clk);
        chkBit(procPending, 1'b0);
        chkBit(notes.size() == 0, 1'b1);
        conclude();
    end
endmodule : tb
bind gate_exec gate_exec_sva chk (.clk(clk), .resetn(resetn), .insValid(insValid),
    .insReady(insReady), .insWord(insWord), .idxRdReq(idxRdReq), .idxRdData(idxRdData),
    .idxRdAddr(idxRdAddr), .flagsKeep(flagsKeep), .rangeError(rangeError), .procReq(procReq),
    .procService(procService), .timeService(timeService), .procPending(procPending),
    .gateClosed(gateClosed));
`default_nettype wire
